//--- pfsf_map.vh
// Contract
// - Overheat fault event sets temperature bit 7, which holds 1 until cleared.
// - Overheat warning event sets temperature bit 6; it reads 0 if none occurred.
// - Temperature bits 5 to 0 always read zero.
// - Each link_error_flag-logic-memory flag clears on clear-all command or a written 1.
// - Bad command code sets link_error_flag-logic-memory bit 7.
// - Bad or unsupported data sets link_error_flag-logic-memory bit 6.
// - Packet error check failure sets link_error_flag-logic-memory bit 5.
// - Internal memory error sets link_error_flag-logic-memory bit 4.
// - Internal logic core error sets link_error_flag-logic-memory bit 3.
// - Communication error sets link_error_flag-logic-memory bit 1.
// - Link_error_flag-logic-memory bits 2 and 0 always read zero.
// - A loop follower reports a back-channel fault as a communication error.
// - Each summary bit is the OR of its detailed byte's implemented flags.
// - Clearing the detailed flags by written ones also clears the summary bit.
// - Every alert-capable flag has its own mask bit that blocks the alert.
// - Other-status bit 0 latches 1 when this device asserted the alert first.
// - That bit reads 0 when alert is idle, cleared, or another device was first.
// - Host uses write byte and read byte; codes 7d, 7e and 7f select the bytes.
// - A read of the link_error_flag-logic-memory code returns exactly one data byte.
// - Writing a read-only code counts as a bad command and notifies the host.
`ifndef PFSF_MAP_VH
`define PFSF_MAP_VH

// ************************************************************
// Command codes
// ************************************************************
`define PFSF_CMD_CLEAR_FAULTS  8'h03
`define PFSF_CMD_STATUS_BYTE   8'h78
`define PFSF_CMD_TEMP_STATUS   8'h7d
`define PFSF_CMD_CML_STATUS    8'h7e
`define PFSF_CMD_OTHER_STATUS  8'h7f
`define PFSF_CMD_TEMP_MASK     8'hd0
`define PFSF_CMD_CML_MASK      8'hd1
`define PFSF_CMD_OTHER_MASK    8'hd2

// ************************************************************
// Field positions and implemented bits
// ************************************************************
`define PFSF_TEMP_FAULT_BIT    7
`define PFSF_TEMP_WARN_BIT     6
`define PFSF_TEMP_IMPL         8'hc0
`define PFSF_CML_BADCMD_BIT    7
`define PFSF_CML_BADDATA_BIT   6
`define PFSF_CML_PEC_BIT       5
`define PFSF_CML_MEM_BIT       4
`define PFSF_CML_CORE_BIT      3
`define PFSF_CML_LINK_BIT      1
`define PFSF_CML_IMPL          8'hfa
`define PFSF_OTHER_FIRST_BIT   0
`define PFSF_OTHER_IMPL        8'h01
`define PFSF_SUM_OTHER_BIT     0
`define PFSF_SUM_CML_BIT       1
`define PFSF_SUM_TEMP_BIT      2

// ************************************************************
// Reset values
// ************************************************************
`define PFSF_STATUS_RST        8'h00
`define PFSF_MASK_RST          8'h00

`endif

//--- pfsf_flag_byte.v
`include "pfsf_map.vh"

module pfsf_flag_byte #(
  parameter [7:0] IMPL = 8'hff
) (
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // Events and clears
  input  wire [7:0] set_i,
  input  wire [7:0] w1c_i,
  input  wire       clr_all_i,
  // Latched flags
  output wire [7:0] flags_o
);

  // ************************************************************
  // Per-bit sticky flags
  // ************************************************************
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bit
      if (IMPL[b]) begin : g_impl
        reg flag_q;
        // A set in the same cycle as a clear wins, so no event is lost.
        always @(posedge core_clk_i or posedge rst_i) begin
          if (rst_i) begin
            flag_q <= 1'b0;
          end else if (ce_i) begin
            if (set_i[b]) begin
              flag_q <= 1'b1;
            end else if (clr_all_i || w1c_i[b]) begin
              flag_q <= 1'b0;
            end
          end
        end
        assign flags_o[b] = flag_q;
      end else begin : g_zero
        assign flags_o[b] = 1'b0;
      end
    end
  endgenerate

endmodule // pfsf_flag_byte

//--- pfsf_status_regs.v
`include "pfsf_map.vh"

module pfsf_status_regs (
  // Clock, reset and enable
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // Command port from the bus protocol engine
  input  wire       cmd_valid_i,
  input  wire       cmd_write_i,
  input  wire [7:0] cmd_code_i,
  input  wire [7:0] cmd_wdata_i,
  input  wire       cmd_has_data_i,
  output wire [7:0] rd_data_o,
  output wire       rd_valid_o,
  output wire       cmd_reject_o,
  // Fault detector events, one-cycle pulses
  input  wire       overheat_fault_i,
  input  wire       overheat_warn_i,
  input  wire       bad_data_i,
  input  wire       pec_fail_i,
  input  wire       mem_error_i,
  input  wire       logic_core_fault_i,
  input  wire       link_error_i,
  input  wire       backchannel_fault_i,
  // Pins
  input  wire       loop_follower_i,
  input  wire       alert_line_i,
  output wire       alert_line_o,
  output wire       alert_line_oe_o,
  // Summary bits and alert
  output wire       sum_temp_o,
  output wire       sum_cml_o,
  output wire       sum_other_o,
  output wire       alert_o
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  reg [1:0] follower_sync_q;
  reg [1:0] line_sync_q;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      follower_sync_q <= 2'h0;
      line_sync_q     <= 2'h0;
    end else if (ce_i) begin
      follower_sync_q <= {follower_sync_q[0], loop_follower_i};
      line_sync_q     <= {line_sync_q[0], alert_line_i};
    end
  end

  wire is_follower = follower_sync_q[1];
  wire line_active = line_sync_q[1];

  // ************************************************************
  // Command decode
  // ************************************************************
  wire cmd_go    = cmd_valid_i & ce_i;
  wire is_clear  = (cmd_code_i == `PFSF_CMD_CLEAR_FAULTS);
  wire is_sbyte  = (cmd_code_i == `PFSF_CMD_STATUS_BYTE);
  wire is_temp   = (cmd_code_i == `PFSF_CMD_TEMP_STATUS);
  wire is_cml    = (cmd_code_i == `PFSF_CMD_CML_STATUS);
  wire is_other  = (cmd_code_i == `PFSF_CMD_OTHER_STATUS);
  wire is_tmask  = (cmd_code_i == `PFSF_CMD_TEMP_MASK);
  wire is_cmask  = (cmd_code_i == `PFSF_CMD_CML_MASK);
  wire is_omask  = (cmd_code_i == `PFSF_CMD_OTHER_MASK);

  wire byte_rw   = is_temp | is_cml | is_other | is_tmask | is_cmask | is_omask;
  wire known     = byte_rw | is_clear | is_sbyte;

  // Clear-all is a send-byte; it is the only write taken without data.
  wire clear_ok  = cmd_go & cmd_write_i & is_clear & ~cmd_has_data_i;
  wire wr_ok     = cmd_go & cmd_write_i & byte_rw & cmd_has_data_i;
  wire rd_ok     = cmd_go & ~cmd_write_i & (byte_rw | is_sbyte);

  // The summary byte is read-only, so writing it is a bad command.
  wire wr_ro     = cmd_go & cmd_write_i & is_sbyte;
  wire bad_cmd   = cmd_go & (~known | wr_ro |
                   (cmd_write_i & byte_rw & ~cmd_has_data_i) |
                   (cmd_write_i & is_clear & cmd_has_data_i) |
                   (~cmd_write_i & is_clear));

  // ************************************************************
  // Event routing into the flag bytes
  // ************************************************************
  reg [7:0] temp_set;
  reg [7:0] cml_set;

  always @* begin
    temp_set = 8'h00;
    temp_set[`PFSF_TEMP_FAULT_BIT] = overheat_fault_i;
    temp_set[`PFSF_TEMP_WARN_BIT]  = overheat_warn_i;
  end

  always @* begin
    cml_set = 8'h00;
    cml_set[`PFSF_CML_BADCMD_BIT]  = bad_cmd;
    cml_set[`PFSF_CML_BADDATA_BIT] = bad_data_i;
    cml_set[`PFSF_CML_PEC_BIT]     = pec_fail_i;
    cml_set[`PFSF_CML_MEM_BIT]     = mem_error_i;
    cml_set[`PFSF_CML_CORE_BIT]    = logic_core_fault_i;
    // Back-channel trouble only counts once this part is a follower.
    cml_set[`PFSF_CML_LINK_BIT]    = link_error_i |
                                     (backchannel_fault_i & is_follower);
  end

  // Reserved bits are dropped by the flag bytes themselves.
  wire [7:0] temp_w1c  = (wr_ok & is_temp)  ? cmd_wdata_i : 8'h00;
  wire [7:0] cml_w1c   = (wr_ok & is_cml)   ? cmd_wdata_i : 8'h00;
  wire [7:0] other_w1c = (wr_ok & is_other) ? cmd_wdata_i : 8'h00;

  // ************************************************************
  // Flag bytes
  // ************************************************************
  wire [7:0] temp_flags;
  wire [7:0] cml_flags;
  wire [7:0] other_flags;
  wire [7:0] other_set;
  wire       first_clr;

  pfsf_flag_byte #(
    .IMPL (`PFSF_TEMP_IMPL)
  ) u_temp (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .set_i      (temp_set),
    .w1c_i      (temp_w1c),
    .clr_all_i  (clear_ok),
    .flags_o    (temp_flags)
  );

  pfsf_flag_byte #(
    .IMPL (`PFSF_CML_IMPL)
  ) u_cml (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .set_i      (cml_set),
    .w1c_i      (cml_w1c),
    .clr_all_i  (clear_ok),
    .flags_o    (cml_flags)
  );

  pfsf_flag_byte #(
    .IMPL (`PFSF_OTHER_IMPL)
  ) u_other (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .set_i      (other_set),
    .w1c_i      (other_w1c),
    .clr_all_i  (first_clr),
    .flags_o    (other_flags)
  );

  // ************************************************************
  // Alert masks
  // ************************************************************
  reg [7:0] temp_mask_q;
  reg [7:0] cml_mask_q;
  reg [7:0] other_mask_q;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      temp_mask_q  <= `PFSF_MASK_RST;
      cml_mask_q   <= `PFSF_MASK_RST;
      other_mask_q <= `PFSF_MASK_RST;
    end else if (wr_ok) begin
      if (is_tmask) begin
        temp_mask_q <= cmd_wdata_i & `PFSF_TEMP_IMPL;
      end
      if (is_cmask) begin
        cml_mask_q <= cmd_wdata_i & `PFSF_CML_IMPL;
      end
      if (is_omask) begin
        other_mask_q <= cmd_wdata_i & `PFSF_OTHER_IMPL;
      end
    end
  end

  // ************************************************************
  // Summary and alert
  // ************************************************************
  // Summaries follow the flags directly, so a written-one clear empties them too.
  assign sum_temp_o  = |(temp_flags & `PFSF_TEMP_IMPL);
  assign sum_cml_o   = |(cml_flags & `PFSF_CML_IMPL);
  assign sum_other_o = |(other_flags & `PFSF_OTHER_IMPL);

  // The earliest-alerter flag is kept out of the alert term: it only exists
  // while the alert is held, and feeding it back would hold the alert forever.
  wire alert_cause = |(temp_flags & ~temp_mask_q) |
                     |(cml_flags & ~cml_mask_q);

  reg alert_q;
  reg line_seen_q;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_q     <= 1'b0;
      line_seen_q <= 1'b0;
    end else if (ce_i) begin
      alert_q     <= alert_cause;
      line_seen_q <= line_active;
    end
  end

  assign alert_o         = alert_q;
  assign alert_line_o    = 1'b0;
  assign alert_line_oe_o = alert_q;

  // Our alert rose while no other device held the shared line. The line is
  // seen through the synchroniser, so a rival that pulled it low less than
  // two cycles earlier cannot be told apart from a tie; we claim the tie.
  wire alert_rise = alert_cause & ~alert_q;
  assign other_set = {7'h00, alert_rise & ~line_seen_q & ~line_active};

  // Dropping the alert or clear-all clears it; an own written one as well.
  assign first_clr = clear_ok | (alert_q & ~alert_cause);

  // ************************************************************
  // Read answer
  // ************************************************************
  reg [7:0] rd_next;
  reg [7:0] rd_data_q;
  reg       rd_valid_q;
  reg       reject_q;

  always @* begin
    rd_next = 8'h00;
    case (cmd_code_i)
      `PFSF_CMD_STATUS_BYTE: begin
        rd_next[`PFSF_SUM_TEMP_BIT]  = sum_temp_o;
        rd_next[`PFSF_SUM_CML_BIT]   = sum_cml_o;
        rd_next[`PFSF_SUM_OTHER_BIT] = sum_other_o;
      end
      `PFSF_CMD_TEMP_STATUS: begin
        rd_next = temp_flags;
      end
      `PFSF_CMD_CML_STATUS: begin
        rd_next = cml_flags;
      end
      `PFSF_CMD_OTHER_STATUS: begin
        rd_next = other_flags;
      end
      `PFSF_CMD_TEMP_MASK: begin
        rd_next = temp_mask_q;
      end
      `PFSF_CMD_CML_MASK: begin
        rd_next = cml_mask_q;
      end
      `PFSF_CMD_OTHER_MASK: begin
        rd_next = other_mask_q;
      end
      default: begin
        rd_next = 8'h00;
      end
    endcase
  end

  // One byte per read, answered on the next edge and held until the next read.
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q  <= `PFSF_STATUS_RST;
      rd_valid_q <= 1'b0;
      reject_q   <= 1'b0;
    end else if (ce_i) begin
      rd_valid_q <= rd_ok;
      reject_q   <= bad_cmd;
      if (rd_ok) begin
        rd_data_q <= rd_next;
      end
    end
  end

  assign rd_data_o    = rd_data_q;
  assign rd_valid_o   = rd_valid_q;
  assign cmd_reject_o = reject_q;

endmodule // pfsf_status_regs

//--- pfsf_props.sv
module pfsf_checker (
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  // Command port
  input wire logic       cmd_valid_i,
  input wire logic       cmd_write_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic       cmd_has_data_i,
  input wire logic       rd_valid_o,
  input wire logic       cmd_reject_o,
  // Events and lines
  input wire logic       overheat_fault_i,
  input wire logic       overheat_warn_i,
  input wire logic       bad_data_i,
  input wire logic       pec_fail_i,
  input wire logic       mem_error_i,
  input wire logic       logic_core_fault_i,
  input wire logic       link_error_i,
  input wire logic       backchannel_fault_i,
  input wire logic       alert_line_i,
  // Summaries and alert
  input wire logic       sum_temp_o,
  input wire logic       sum_cml_o,
  input wire logic       sum_other_o,
  input wire logic       alert_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // A set in the same cycle beats any clear, so clear checks need a quiet cycle.
  wire quiet = !(overheat_fault_i | overheat_warn_i | bad_data_i | pec_fail_i | mem_error_i
                 | logic_core_fault_i | link_error_i | backchannel_fault_i);
  sequence s_cmd(w, c);
    cmd_valid_i && ce_i && cmd_write_i == w && cmd_code_i == c;
  endsequence
  AST_RD_ONE: assert property (s_cmd(1'b0, 8'h7e) |=> rd_valid_o && !cmd_reject_o)
    else $error("read gave no single answer");
  AST_RO_WRITE: assert property (s_cmd(1'b1, 8'h78) |=> cmd_reject_o && sum_cml_o && !rd_valid_o)
    else $error("read-only write not refused");
  AST_TEMP_SET: assert property (ce_i && overheat_fault_i |=> sum_temp_o)
    else $error("overheat fault not latched");
  AST_CML_SET: assert property (ce_i && (bad_data_i || pec_fail_i || mem_error_i || logic_core_fault_i
                                || link_error_i) |=> sum_cml_o)
    else $error("cml summary missing");
  AST_CLEAR_ALL: assert property (s_cmd(1'b1, 8'h03) ##0 (!cmd_has_data_i && quiet)
                                  |=> !sum_temp_o && !sum_cml_o)
    else $error("clear-all left flags");
  AST_W1C_SUM: assert property (s_cmd(1'b1, 8'h7e) ##0 (cmd_has_data_i && (cmd_wdata_i & 8'hfa) == 8'hfa
                                && quiet) |=> !sum_cml_o)
    else $error("write-one clear left summary");
  AST_ALERT_CAUSE: assert property ($rose(alert_o) |-> $past(sum_temp_o || sum_cml_o))
    else $error("alert without flag");
  AST_FIRST_ALERT: assert property ($rose(sum_other_o) |-> $rose(alert_o))
    else $error("first flag without own alert");
  AST_NOT_FIRST: assert property ($rose(sum_other_o) |-> !$past(alert_line_i, 3) && !$past(alert_line_i, 4))
    else $error("first flag while line busy");
endmodule // pfsf_checker

bind pfsf_status_regs pfsf_checker pfsf_checker_i (.*);

//--- pfsf_host.sv
module pfsf_host (
  // Clock
  input  wire logic       clk_i,
  // Command side
  output logic            valid_o = 1'b0,
  output logic            write_o = 1'b0,
  output logic            has_data_o = 1'b0,
  output logic      [7:0] code_o = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  // Answer side
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  input  wire logic       reject_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Byte transfers
  // ****************************************
  logic [7:0] got;
  logic       rv;
  logic       rj;
  // Released lines show inverted data so a stale value can never pass.
  task xfer(input logic w, input logic d, input logic [7:0] c, input logic [7:0] wd);
    @(negedge clk_i);
    valid_o = 1'b1;
    write_o = w;
    has_data_o = d;
    code_o = c;
    wdata_o = wd;
    @(negedge clk_i);
    got = rdata_i;
    rv = rvalid_i;
    rj = reject_i;
    valid_o = 1'b0;
    write_o = ~w;
    has_data_o = ~d;
    code_o = ~c;
    wdata_o = ~wd;
  endtask
endmodule // pfsf_host

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       ce_i = 1'b1;
  logic       loop_follower_i = 1'b0;
  logic       other_pull = 1'b0;
  logic [7:0] ev = 8'h00;
  logic       cmd_valid_i, cmd_write_i, cmd_has_data_i;
  logic [7:0] cmd_code_i, cmd_wdata_i;
  wire  [7:0] rd_data_o;
  wire        rd_valid_o, cmd_reject_o, alert_line_o, alert_line_oe_o;
  wire        sum_temp_o, sum_cml_o, sum_other_o, alert_o;
  wire        overheat_fault_i = ev[0];
  wire        overheat_warn_i = ev[1];
  wire        bad_data_i = ev[2];
  wire        pec_fail_i = ev[3];
  wire        mem_error_i = ev[4];
  wire        logic_core_fault_i = ev[5];
  wire        link_error_i = ev[6];
  wire        backchannel_fault_i = ev[7];
  // Shared alert line: high while any party pulls it.
  wire        alert_line_i = alert_line_oe_o | other_pull;
  int         mismatches = 0;
  int         n_tests = 0;
  logic [7:0] vals [8] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h02};

  pfsf_status_regs pfsf_status_regs_i (.*);
  pfsf_host pfsf_host_i (.clk_i(core_clk_i), .valid_o(cmd_valid_i), .write_o(cmd_write_i),
    .has_data_o(cmd_has_data_i), .code_o(cmd_code_i), .wdata_o(cmd_wdata_i),
    .rdata_i(rd_data_o), .rvalid_i(rd_valid_o), .reject_i(cmd_reject_o));

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task rd(input logic [7:0] c, input logic [7:0] exp);
    pfsf_host_i.xfer(1'b0, 1'b0, c, 8'h00);
    chk1(pfsf_host_i.rv, 1'b1);
    chk8(pfsf_host_i.got, exp);
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    pfsf_host_i.xfer(1'b1, 1'b1, c, d);
  endtask
  task clear_all;
    pfsf_host_i.xfer(1'b1, 1'b0, 8'h03, 8'h00);
  endtask
  task pulse(input logic [7:0] e);
    @(negedge core_clk_i);
    ev = e;
    @(negedge core_clk_i);
    ev = 8'h00;
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    int i;
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    rd(8'h7e, 8'h00);
    rd(8'h7f, 8'h00);
    rd(8'h7d, 8'h00);
    for (i = 0; i < 8; i++) begin
      loop_follower_i = (i == 7);
      repeat (3) @(negedge core_clk_i);
      pulse(8'h01 << i);
      rd(i < 2 ? 8'h7d : 8'h7e, vals[i]);
      chk1(i < 2 ? sum_temp_o : sum_cml_o, 1'b1);
      wr(i < 2 ? 8'h7d : 8'h7e, 8'hff);
      rd(i < 2 ? 8'h7d : 8'h7e, 8'h00);
      chk1(i < 2 ? sum_temp_o : sum_cml_o, 1'b0);
    end
    loop_follower_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    pulse(8'h80);
    rd(8'h7e, 8'h00);
    wr(8'h78, 8'h00);
    chk1(pfsf_host_i.rj, 1'b1);
    rd(8'h7e, 8'h80);
    pfsf_host_i.xfer(1'b0, 1'b0, 8'h55, 8'h00);
    chk1(pfsf_host_i.rv, 1'b0);
    chk1(pfsf_host_i.rj, 1'b1);
    clear_all();
    rd(8'h7e, 8'h00);
    wr(8'hd1, 8'hff);
    rd(8'hd1, 8'hfa);
    pulse(8'h04);
    repeat (3) @(negedge core_clk_i);
    chk1(alert_o, 1'b0);
    chk1(sum_cml_o, 1'b1);
    clear_all();
    wr(8'hd1, 8'h00);
    other_pull = 1'b1;
    repeat (4) @(negedge core_clk_i);
    pulse(8'h01);
    repeat (3) @(negedge core_clk_i);
    chk1(alert_o, 1'b1);
    rd(8'h7f, 8'h00);
    clear_all();
    other_pull = 1'b0;
    repeat (5) @(negedge core_clk_i);
    pulse(8'h01);
    repeat (3) @(negedge core_clk_i);
    chk1(alert_line_oe_o, 1'b1);
    chk1(alert_line_o, 1'b0);
    rd(8'h7f, 8'h01);
    chk1(sum_other_o, 1'b1);
    rd(8'h78, 8'h05);
    wr(8'h7f, 8'h01);
    rd(8'h7f, 8'h00);
    clear_all();
    repeat (3) @(negedge core_clk_i);
    rd(8'h7f, 8'h00);
    give_verdict();
  end
  // The whole sequence needs under two hundred cycles; this limit is far beyond it.
  initial begin
    #50000;
    mismatches++;
    give_verdict();
  end
endmodule // tb_top
